// file: core/burst_sram_bank_control.sv
// Bank controller: decode, byte-lane writes, termination, burst addressing
//
// Summary of operation
// R1 - Fast variant: burst of four words, first two clocks in, then one each.
// R2 - Single non-burst read completes in two clock periods.
// R3 - Decode bank window on address bits 18 to 20; ignore other addresses.
// R4 - Byte-lane selects only on bank writes, per size and low address bits.
// R5 - Lanes 3..0 cover data bits 31-24, 23-16, 15-8, 7-0.
// R6 - Byte-lane selects gated by asserted address strobe.
// R7 - Read buffer enable gated by strobe; memory chips always enabled.
// R8 - Read termination comes straight from the address decode.
// R9 - Writes qualified by one-clock delayed strobe, lasting three clocks.
// R10 - Termination and burst acknowledge assert together.
// R11 - Sole responder: acknowledge held permanently asserted; the code does so only with BURST_GUARD off.
// R12 - Counter preset from long-word address while strobe negated.
// R13 - Writes never burst; counter passes the address straight through.
// R14 - Burst reads advance the counter each beat after strobe asserts.
// R15 - Memory address drivers permanently enabled.
// R16 - Optional: withhold acknowledge on wraparound or long-word crossing.
// R17 - Pipelined variant registers read data, giving 3-1-1-1 bursts.
// R18 - Pipelined variant delays termination one clock for a wait state.
// R19 - Pipelined counter waits until the first word is registered.
// R20 - Counter wraps modulo four; upper address bits stay put.
`timescale 1ns/1ps
`default_nettype none
module burst_sram_bank_control
   import burst_sram_pkg::*;
#(
   parameter bit         PIPELINED      = 1'b0,
   parameter bit         SOLE_RESPONDER = 1'b0,
   parameter bit         BURST_GUARD    = 1'b1,
   parameter logic [2:0] BANK_MATCH     = BANK_MATCH_RST
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              address_strobe_n,
   input  wire logic              bus_read,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              transfer_size_high,
   input  wire logic              transfer_size_low,
   input  wire logic              burst_request_n,
   input  wire logic [DATA_W-1:0] mem_rd_data,
   input  wire logic              stream_ready,
   output logic                   byte_sel_lane3_n,
   output logic                   byte_sel_lane2_n,
   output logic                   byte_sel_lane1_n,
   output logic                   byte_sel_lane0_n,
   output logic                   read_buffer_enable_n,
   output logic                   sync_cycle_terminate_n,
   output logic                   burst_acknowledge_n,
   output logic      [MEM_AW-1:0] mem_addr,
   output logic                   mem_addr_enable,
   output logic                   mem_enable_n,
   output logic      [DATA_W-1:0] cpu_rd_data,
   output logic                   cpu_rd_data_oe,
   output logic      [DATA_W-1:0] stream_data,
   output logic                   stream_valid
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      phase_t            phase;
      logic              hit;
      logic              guard_ok;
      logic              delayed_strobe;
      logic [DATA_W-1:0] data;
   } ctl_state_t;

   ctl_state_t        st_r;
   ctl_state_t        st_nxt;
   logic              strobe;
   logic              hit_now;
   logic [1:0]        size;
   logic [1:0]        a_lo;
   logic [3:0]        lane_hit;
   logic              crosses;
   logic              term;
   logic              stall;
   logic              advance;
   logic              burst_rd;
   logic [CNT_W-1:0]  burst_count_bits;
   logic              fifo_in_ready;

   // Number of bytes moved by one transfer for a given size code
   function automatic logic [2:0] size_bytes(input logic [1:0] sz);
      logic [2:0] n;
      n = 3'h4;
      unique case (sz)
         SIZE_LONG:   n = 3'h4;
         SIZE_BYTE:   n = 3'h1;
         SIZE_WORD:   n = 3'h2;
         SIZE_TRIPLE: n = 3'h3;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address decode and lane selection
   assign strobe  = !address_strobe_n;
   assign size    = {transfer_size_high, transfer_size_low};
   assign a_lo    = addr[1:0];
   assign hit_now = (addr[BANK_HI:BANK_LO] == BANK_MATCH); // [R3]

   // Lane 3 holds byte offset 0, lane 0 offset 3
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_lane
         localparam logic [2:0] OFS = 3'(3 - k);
         assign lane_hit[k] = (OFS >= {1'b0, a_lo}) &&
                              (OFS < 3'({1'b0, a_lo} + size_bytes(size))); // [R4]
      end
   endgenerate

   // Operand running past the end of the long word
   assign crosses = (3'({1'b0, a_lo} + size_bytes(size)) > 3'h4);

   ////////////////////////////////////////////////////////////////////////
   // Cycle sequencing
   always_comb begin
      st_nxt = st_r;
      if (!strobe) begin
         st_nxt.phase          = PH_IDLE;
         st_nxt.hit            = 1'b0;
         st_nxt.delayed_strobe = 1'b0;
      end else begin
         unique case (st_r.phase)
            PH_IDLE: begin
               st_nxt.phase    = PH_FIRST;
               st_nxt.hit      = hit_now;
               // Burst would wrap or the operand straddles long words
               st_nxt.guard_ok = !BURST_GUARD ||
                                 ((addr[LW_HI:LW_LO] == LW_ALIGNED) && !crosses);
            end
            PH_FIRST:  st_nxt.phase = PH_SECOND;
            PH_SECOND: st_nxt.phase = PH_BURST;
            PH_BURST:  st_nxt.phase = PH_BURST;
         endcase
         // Strobe seen one clock earlier within the same cycle
         st_nxt.delayed_strobe = (st_r.phase != PH_IDLE); // [R9] [R18]
      end
      // Data register only frozen while the stream is back-pressured
      if (!stall) begin
         st_nxt.data = mem_rd_data; // [R17]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r.phase          <= PH_IDLE;
         st_r.hit            <= 1'b0;
         st_r.guard_ok       <= 1'b0;
         st_r.delayed_strobe <= 1'b0;
         st_r.data           <= DATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Termination
   // A full read stream holds off the beat rather than dropping a word
   assign stall    = strobe && bus_read && st_r.hit && !fifo_in_ready;
   assign burst_rd = strobe && bus_read && !burst_request_n && st_r.hit;

   always_comb begin
      term = 1'b0;
      if (strobe && st_r.hit) begin
         if (!bus_read) begin
            term = st_r.delayed_strobe; // [R9]
         end else if (PIPELINED) begin
            term = st_r.delayed_strobe && !stall; // [R18]
         end else begin
            term = (st_r.phase != PH_IDLE) && !stall; // [R8] [R2] [R1]
         end
      end
   end

   // Pipelined: address leads the data register by one beat
   always_comb begin
      if (PIPELINED) begin
         advance = burst_rd && (st_r.phase != PH_IDLE) && !stall; // [R19]
      end else begin
         advance = burst_rd && term; // [R14] [R1]
      end
   end

   assign sync_cycle_terminate_n = !term; // [R10]

   always_comb begin
      if (SOLE_RESPONDER) begin
         // Guard result is only fresh once the first strobe cycle has been decoded
         burst_acknowledge_n = !(!BURST_GUARD ||
                                 (strobe && (st_r.phase != PH_IDLE) && st_r.guard_ok)); // [R11]
      end else begin
         burst_acknowledge_n = !(term && st_r.guard_ok); // [R10] [R16]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Burst address generator
   // Address and strobe may arrive on one edge, so the first strobe cycle still loads
   burst_addr_counter u_counter (
      .sys_clk          (sys_clk),
      .sys_rst          (sys_rst),
      .preset           (!strobe || (st_r.phase == PH_IDLE)),
      .base             (addr[LW_HI:LW_LO]),
      .advance          (advance),
      .burst_count_bits (burst_count_bits)
   ); // [R12] [R14]

   assign mem_addr        = {addr[MEM_HI:LW_HI+1], burst_count_bits}; // [R20]
   assign mem_addr_enable = 1'b1; // [R15]
   assign mem_enable_n    = 1'b0; // [R7]

   ////////////////////////////////////////////////////////////////////////
   // Write lane selects and read buffer
   assign byte_sel_lane3_n = !(strobe && !bus_read && hit_now && lane_hit[3]); // [R5] [R6]
   assign byte_sel_lane2_n = !(strobe && !bus_read && hit_now && lane_hit[2]); // [R5] [R6]
   assign byte_sel_lane1_n = !(strobe && !bus_read && hit_now && lane_hit[1]); // [R5] [R6]
   assign byte_sel_lane0_n = !(strobe && !bus_read && hit_now && lane_hit[0]); // [R5] [R6]

   assign read_buffer_enable_n = !(strobe && bus_read && hit_now); // [R7]
   assign cpu_rd_data_oe       = !read_buffer_enable_n;
   // Fast variant passes memory straight through to meet two clocks
   assign cpu_rd_data          = PIPELINED ? st_r.data : mem_rd_data; // [R17]

   ////////////////////////////////////////////////////////////////////////
   // Copy of every terminated read beat for a downstream consumer
   read_stream_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_data   (cpu_rd_data),
      .in_valid  (term && bus_read),
      .in_ready  (fifo_in_ready),
      .out_data  (stream_data),
      .out_valid (stream_valid),
      .out_ready (stream_ready)
   );
endmodule // burst_sram_bank_control
`default_nettype wire

// file: core/burst_sram_pkg.sv
// Shared constants for the burst static memory bank controller
package burst_sram_pkg;
   localparam int ADDR_W       = 32;
   localparam int DATA_W       = 32;
   localparam int BANK_HI      = 20;
   localparam int BANK_LO      = 18;
   localparam int LW_LO        = 2;
   localparam int LW_HI        = 3;
   localparam int MEM_HI       = 17;
   localparam int MEM_AW       = MEM_HI - LW_LO + 1;
   localparam int CNT_W        = 2;
   localparam int FIFO_DEPTH   = 8;
   localparam logic [2:0] BANK_MATCH_RST = 3'h0;
   localparam logic [1:0] CNT_RST        = 2'h0;
   localparam logic [1:0] SIZE_LONG      = 2'h0;
   localparam logic [1:0] SIZE_BYTE      = 2'h1;
   localparam logic [1:0] SIZE_WORD      = 2'h2;
   localparam logic [1:0] SIZE_TRIPLE    = 2'h3;
   localparam logic [1:0] LW_ALIGNED     = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   // Bus phases of one cycle, counted from the first strobe-low cycle
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_FIRST,
      PH_SECOND,
      PH_BURST
   } phase_t;
endpackage

// file: core/burst_addr_counter.sv
// Two-bit burst long-word address counter with strobe-negated preset
`timescale 1ns/1ps
`default_nettype none
module burst_addr_counter
   import burst_sram_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             preset,
   input  wire logic [CNT_W-1:0] base,
   input  wire logic             advance,
   output logic      [CNT_W-1:0] burst_count_bits
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } cnt_state_t;

   cnt_state_t st_r;
   cnt_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (preset) begin
         st_nxt.cnt = base;
      end else if (advance) begin
         st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1); // [R20]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r.cnt <= CNT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Preset acts without waiting for a clock edge, as a buffer would
   assign burst_count_bits = preset ? base : st_r.cnt; // [R12] [R13]
endmodule // burst_addr_counter
`default_nettype wire

// file: core/read_stream_fifo.sv
// Parameterised valid/ready FIFO for the read data stream
`timescale 1ns/1ps
`default_nettype none
module read_stream_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [PW:0]                 fill;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic        push;
   logic        pop;

   always_comb begin
      st_nxt = st_r;
      push   = in_valid && in_ready;
      pop    = out_valid && out_ready;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data;
         st_nxt.wr_ptr = (st_r.wr_ptr == LAST) ? '0 : PW'(st_r.wr_ptr + 1'b1);
      end
      if (pop) begin
         st_nxt.rd_ptr = (st_r.rd_ptr == LAST) ? '0 : PW'(st_r.rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         st_nxt.fill = (PW+1)'(st_r.fill + 1'b1);
      end else if (pop && !push) begin
         st_nxt.fill = (PW+1)'(st_r.fill - 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign in_ready  = (st_r.fill != FULL_CNT);
   assign out_valid = (st_r.fill != '0);
   assign out_data  = st_r.mem[st_r.rd_ptr];
endmodule // read_stream_fifo
`default_nettype wire

// file: tb/burst_sram_chk.sv
// Port-level checks for the burst static memory bank controller
`timescale 1ns/1ps
`default_nettype none
module burst_sram_chk
   import burst_sram_pkg::*;
#(
   parameter logic [2:0] BANK_MATCH = BANK_MATCH_RST,
   parameter bit         PIPELINED  = 1'b0
) (
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic              address_strobe_n,
   input wire logic              bus_read,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              burst_request_n,
   input wire logic              stream_valid,
   input wire logic              byte_sel_lane3_n,
   input wire logic              byte_sel_lane2_n,
   input wire logic              byte_sel_lane1_n,
   input wire logic              byte_sel_lane0_n,
   input wire logic              read_buffer_enable_n,
   input wire logic              sync_cycle_terminate_n,
   input wire logic              burst_acknowledge_n,
   input wire logic [MEM_AW-1:0] mem_addr,
   input wire logic              mem_addr_enable,
   input wire logic              mem_enable_n,
   input wire logic              cpu_rd_data_oe
);
   logic hit;
   logic lanes_off;
   logic term_n;
   assign hit = addr[BANK_HI:BANK_LO] == BANK_MATCH;
   assign lanes_off = byte_sel_lane3_n & byte_sel_lane2_n & byte_sel_lane1_n & byte_sel_lane0_n;
   assign term_n = sync_cycle_terminate_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   a_lane_gate: assert property (address_strobe_n || bus_read || !hit |-> lanes_off)
      else $error("Lane select outside a bank write");
   a_rdbuf_gate: assert property (
      read_buffer_enable_n == (address_strobe_n || !bus_read || !hit)
      && cpu_rd_data_oe == !read_buffer_enable_n) else $error("Read buffer enable wrong");
   a_mem_on: assert property (mem_addr_enable && !mem_enable_n)
      else $error("Memory or address drivers disabled");
   a_read_two: assert property (!PIPELINED && $fell(address_strobe_n) && bus_read
      && hit && !stream_valid |-> term_n ##1 !term_n)
      else $error("Read not ended in two clocks");
   a_read_three: assert property (PIPELINED && $fell(address_strobe_n) && bus_read
      && hit && !stream_valid |-> term_n [*2] ##1 !term_n)
      else $error("Pipelined read not ended in three clocks");
   a_write_three: assert property ($fell(address_strobe_n) && !bus_read && hit
      |-> term_n [*2] ##1 !term_n) else $error("Write not ended in three clocks");
   a_miss_quiet: assert property (
      !hit |-> term_n && burst_acknowledge_n && read_buffer_enable_n)
      else $error("Response outside the bank window");
   a_ack_term: assert property (!burst_acknowledge_n |-> !term_n)
      else $error("Acknowledge without termination");
   a_burst_step: assert property (!term_n && !$past(term_n)
      && !$past(burst_request_n) && bus_read
      |-> mem_addr == {$past(mem_addr[MEM_AW-1:2]), $past(mem_addr[1:0]) + 2'h1})
      else $error("Burst address step wrong");
   a_addr_pass: assert property (
      address_strobe_n || !bus_read |-> mem_addr == addr[MEM_HI:LW_LO])
      else $error("Memory address not passed through");
endmodule // burst_sram_chk
`default_nettype wire

// file: tb/cpu_bus_model.sv
// Processor-side bus master model for the bank controller
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
   import burst_sram_pkg::*;
(
   input  wire logic              sys_clk,
   output logic                   address_strobe_n,
   output logic                   bus_read,
   output logic      [ADDR_W-1:0] addr,
   output logic                   transfer_size_high,
   output logic                   transfer_size_low,
   output logic                   burst_request_n,
   input  wire logic              sync_cycle_terminate_n,
   input  wire logic              burst_acknowledge_n,
   input  wire logic [3:0]        lanes_n,
   input  wire logic [DATA_W-1:0] cpu_rd_data
);
   logic [DATA_W-1:0] got [4];
   logic [3:0]        lanes_seen;
   logic              ack_seen;
   int                first;
   int                last;
   initial begin
      address_strobe_n = 1'b1;
      bus_read = 1'b1;
      addr = 32'h0000_0000;
      {transfer_size_high, transfer_size_low} = 2'h0;
      burst_request_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task automatic cycle(input logic rd, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
                        input logic brq, input int beats);
      int n;
      int t;
      n = 0;
      t = 0;
      first = 0;
      ack_seen = 1'b0;
      @(posedge sys_clk);
      address_strobe_n <= 1'b0;
      bus_read <= rd;
      addr <= a;
      {transfer_size_high, transfer_size_low} <= sz;
      burst_request_n <= !(brq && rd);
      while (n < beats && t < 12) begin
         @(negedge sys_clk);
         t++;
         if (t == 1) lanes_seen = lanes_n;
         if (sync_cycle_terminate_n === 1'b0) begin
            if (n == 0) first = t;
            if (n == 0) ack_seen = burst_acknowledge_n === 1'b0;
            got[n] = cpu_rd_data;
            n++;
            // No acknowledge: the processor falls back to a single transfer
            if (burst_acknowledge_n !== 1'b0) beats = n;
         end
      end
      last = t;
      @(posedge sys_clk);
      // Released address and direction lines show the inverse, not a stale copy
      address_strobe_n <= 1'b1;
      burst_request_n <= 1'b1;
      addr <= ~a;
      bus_read <= ~rd;
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// file: tb/tb_burst_sram_bank_control.sv
// Self-checking bench for the burst static memory bank controller
`timescale 1ns/1ps
`default_nettype none
module tb_burst_sram_bank_control;
   import burst_sram_pkg::*;
   localparam logic [2:0]        BANK_MATCH = 3'h5;
   localparam logic [ADDR_W-1:0] BASE       = 32'h0014_0000;
   logic sys_clk = 1'b0;
   logic sys_rst;
   logic stream_ready;
   logic address_strobe_n, bus_read, transfer_size_high, transfer_size_low, burst_request_n;
   logic l3_n, l2_n, l1_n, l0_n, rdbuf_n, term_n, ack_n, stream_valid;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] mem_rd_data, cpu_rd_data, stream_data;
   logic [MEM_AW-1:0] mem_addr;
   logic [DATA_W-1:0] popped [$];
   logic p_as_n, p_rd, p_szh, p_szl, p_brq_n, p3_n, p2_n, p1_n, p0_n, p_term_n, p_ack_n;
   logic [ADDR_W-1:0] p_addr;
   logic [DATA_W-1:0] p_mem_rd, p_rd_data;
   logic [MEM_AW-1:0] p_mem_addr;
   int err_count = 0;
   int checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   assign mem_rd_data = {16'ha5c3, mem_addr};
   burst_sram_bank_control #(.BANK_MATCH(BANK_MATCH)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .address_strobe_n(address_strobe_n), .bus_read(bus_read), .addr(addr),
      .transfer_size_high(transfer_size_high), .transfer_size_low(transfer_size_low),
      .burst_request_n(burst_request_n), .mem_rd_data(mem_rd_data), .stream_ready(stream_ready),
      .byte_sel_lane3_n(l3_n), .byte_sel_lane2_n(l2_n), .byte_sel_lane1_n(l1_n),
      .byte_sel_lane0_n(l0_n), .read_buffer_enable_n(rdbuf_n), .sync_cycle_terminate_n(term_n),
      .burst_acknowledge_n(ack_n), .mem_addr(mem_addr), .mem_addr_enable(), .mem_enable_n(),
      .cpu_rd_data(cpu_rd_data), .cpu_rd_data_oe(), .stream_data(stream_data),
      .stream_valid(stream_valid));
   cpu_bus_model cpu_u (.sys_clk(sys_clk), .address_strobe_n(address_strobe_n),
      .bus_read(bus_read), .addr(addr), .transfer_size_high(transfer_size_high),
      .transfer_size_low(transfer_size_low), .burst_request_n(burst_request_n),
      .sync_cycle_terminate_n(term_n), .burst_acknowledge_n(ack_n),
      .lanes_n({l3_n, l2_n, l1_n, l0_n}), .cpu_rd_data(cpu_rd_data));
   // Pipelined twin on a bus of its own
   assign p_mem_rd = {16'ha5c3, p_mem_addr};
   burst_sram_bank_control #(.BANK_MATCH(BANK_MATCH), .PIPELINED(1'b1)) dut_pipe (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .address_strobe_n(p_as_n), .bus_read(p_rd),
      .addr(p_addr), .transfer_size_high(p_szh), .transfer_size_low(p_szl),
      .burst_request_n(p_brq_n), .mem_rd_data(p_mem_rd), .stream_ready(stream_ready),
      .byte_sel_lane3_n(p3_n), .byte_sel_lane2_n(p2_n), .byte_sel_lane1_n(p1_n),
      .byte_sel_lane0_n(p0_n), .read_buffer_enable_n(), .sync_cycle_terminate_n(p_term_n),
      .burst_acknowledge_n(p_ack_n), .mem_addr(p_mem_addr), .mem_addr_enable(),
      .mem_enable_n(), .cpu_rd_data(p_rd_data), .cpu_rd_data_oe(), .stream_data(),
      .stream_valid());
   cpu_bus_model cpu_pipe (.sys_clk(sys_clk), .address_strobe_n(p_as_n), .bus_read(p_rd),
      .addr(p_addr), .transfer_size_high(p_szh), .transfer_size_low(p_szl),
      .burst_request_n(p_brq_n), .sync_cycle_terminate_n(p_term_n),
      .burst_acknowledge_n(p_ack_n), .lanes_n({p3_n, p2_n, p1_n, p0_n}),
      .cpu_rd_data(p_rd_data));
   always @(posedge sys_clk) begin
      if (stream_valid === 1'b1 && stream_ready === 1'b1) popped.push_back(stream_data);
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [DATA_W-1:0] exp_w(input logic [ADDR_W-1:0] a);
      return {16'ha5c3, a[MEM_HI:LW_LO]};
   endfunction
   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         err_count++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task automatic t_reads();
      logic [ADDR_W-1:0] a;
      a = BASE + 32'h0000_0104;
      cpu_u.cycle(1'b1, a, 2'h0, 1'b0, 1);
      chk(cpu_u.first == 2 && cpu_u.got[0] === exp_w(a), "single read");
      a = BASE + 32'h0000_0200;
      cpu_u.cycle(1'b1, a, 2'h0, 1'b1, 4);
      chk(cpu_u.first == 2 && cpu_u.last == 5 && cpu_u.ack_seen, "burst timing");
      for (int i = 0; i < 4; i++) begin
         chk(cpu_u.got[i] === exp_w(a + 4 * i), "burst data");
      end
      cpu_u.cycle(1'b1, BASE + 32'h0000_0308, 2'h0, 1'b1, 4);
      chk(cpu_u.last == 2 && !cpu_u.ack_seen, "burst not withheld");
      cpu_u.cycle(1'b1, BASE + 32'h0000_0203, 2'h2, 1'b1, 4);
      chk(cpu_u.last == 2 && !cpu_u.ack_seen, "crossing burst not withheld");
      cpu_u.cycle(1'b1, 32'h0004_0000, 2'h0, 1'b0, 1);
      chk(cpu_u.first == 0, "read outside bank answered");
   endtask
   task automatic t_writes();
      logic [3:0] m;
      for (int s = 0; s < 4; s++) begin
         for (int o = 0; o < 4; o++) begin
            m = 4'h0;
            for (int k = o; k < o + (s == 0 ? 4 : s) && k < 4; k++) m[3 - k] = 1'b1;
            cpu_u.cycle(1'b0, BASE + o, 2'(s), 1'b0, 1);
            chk(cpu_u.lanes_seen === ~m && cpu_u.first == 3, "write lanes");
         end
      end
      cpu_u.cycle(1'b0, 32'h0000_0000, 2'h0, 1'b0, 1);
      chk(cpu_u.lanes_seen === 4'hf && cpu_u.first == 0, "write outside bank");
   endtask
   task automatic t_fifo();
      stream_ready <= 1'b0;
      popped.delete();
      cpu_u.cycle(1'b1, BASE, 2'h0, 1'b1, 4);
      cpu_u.cycle(1'b1, BASE + 32'h0000_0010, 2'h0, 1'b1, 4);
      fork
         cpu_u.cycle(1'b1, BASE + 32'h0000_0020, 2'h0, 1'b0, 1);
         begin
            repeat (6) @(posedge sys_clk);
            stream_ready <= 1'b1;
         end
      join
      chk(cpu_u.first == 7 && cpu_u.got[0] === exp_w(BASE + 32'h0000_0020), "full buffer stall");
      repeat (12) @(posedge sys_clk);
      chk(popped.size() == 9 && popped[0] === exp_w(BASE)
          && popped[8] === exp_w(BASE + 32'h0000_0020), "stream order");
   endtask
   task automatic t_pipe();
      logic [ADDR_W-1:0] a;
      a = BASE + 32'h0000_0104;
      cpu_pipe.cycle(1'b1, a, 2'h0, 1'b0, 1);
      chk(cpu_pipe.first == 3 && cpu_pipe.got[0] === exp_w(a), "pipe single");
      a = BASE + 32'h0000_0200;
      cpu_pipe.cycle(1'b1, a, 2'h0, 1'b1, 4);
      chk(cpu_pipe.first == 3 && cpu_pipe.last == 6 && cpu_pipe.ack_seen, "pipe burst");
      for (int i = 0; i < 4; i++) begin
         chk(cpu_pipe.got[i] === exp_w(a + 4 * i), "pipe burst data");
      end
      cpu_pipe.cycle(1'b0, BASE + 32'h0000_0001, 2'h1, 1'b0, 1);
      chk(cpu_pipe.lanes_seen === 4'hb && cpu_pipe.first == 3, "pipe write");
   endtask
   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      stream_ready = 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reads();
      t_writes();
      t_fifo();
      t_pipe();
      end_sim();
   end
   // Whole run is under two hundred cycles; this leaves ample margin
   initial begin
      #20000;
      err_count++;
      end_sim();
   end
endmodule // tb_burst_sram_bank_control
bind burst_sram_bank_control burst_sram_chk #(.BANK_MATCH(BANK_MATCH), .PIPELINED(PIPELINED))
   chk_u (.sys_clk, .sys_rst,
   .address_strobe_n, .bus_read, .addr, .burst_request_n, .stream_valid, .byte_sel_lane3_n,
   .byte_sel_lane2_n, .byte_sel_lane1_n, .byte_sel_lane0_n, .read_buffer_enable_n,
   .sync_cycle_terminate_n, .burst_acknowledge_n, .mem_addr, .mem_addr_enable, .mem_enable_n,
   .cpu_rd_data_oe);
`default_nettype wire
